// [src/dri_pkg.sv]
// Constants shared by the readback block, its FIFO and its register port.
package dri_pkg;
  localparam int         FIFO_WIDTH      = 8;
  localparam int         FIFO_DEPTH      = 8;
  localparam int         NUM_CHAN        = 4;
  localparam int         CHAN_W          = 12;
  localparam logic [4:0] ADDR_PREFIX     = 5'h13;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [1:0] BYTES_NO_PD     = 2'h2;
  localparam logic [1:0] BYTES_WITH_PD   = 2'h3;
  localparam logic [5:0] PD_BYTE_FILL    = 6'h3f;
  localparam logic [5:0] LO_BYTE_FILL    = 6'h00;
  localparam logic [7:0] IDLE_TX_BYTE    = 8'hff;
  localparam int         CTRL_SEL_POS    = 1;
  localparam int         CTRL_PD_POS     = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 12'h000;
  localparam int         PD_MODE_POS     = 10;
  localparam logic [1:0] PD_MODE_1K      = 2'h1;
  localparam logic [1:0] PD_MODE_100K    = 2'h2;
  localparam logic [2:0] REG_CHAN0       = 3'h0;
  localparam logic [2:0] REG_CTRL        = 3'h4;
  localparam logic [2:0] REG_STATUS      = 3'h5;
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CTRL, ST_CTRL_ACK, ST_TX, ST_MACK, ST_IGNORE
  } dri_state_e;
endpackage : dri_pkg

// [src/dri_stream_if.sv]
// Byte stream between the readback engine and its transmit FIFO.
`timescale 1ns/1ns
interface dri_stream_if;
  logic       inValid;
  logic       inReady;
  logic [7:0] inData;
  logic       outValid;
  logic       outReady;
  logic [7:0] outData;
  logic       flush;
  modport fifo (input inValid, input inData, input outReady, input flush,
                output inReady, output outValid, output outData);
  modport user (output inValid, output inData, output outReady, output flush,
                input inReady, input outValid, input outData);
endinterface : dri_stream_if

// [src/dri_fifo.sv]
// Synchronous FIFO with valid and ready on both sides and a flush.
`timescale 1ns/1ns
module dri_fifo
  import dri_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  dri_stream_if.fifo st
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign st.inReady  = (count_reg != (AW+1)'(DEPTH));
  assign st.outValid = (count_reg != '0);
  assign st.outData  = mem[rdPtr_reg];
  assign push        = st.inValid && st.inReady;
  assign pop         = st.outValid && st.outReady;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= st.inData;
    end
  end

  // Pointers and count; a flush empties the FIFO at once.
  always_ff @(posedge clk) begin
    if (rst || st.flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dri_fifo

// [src/dri_readback.sv]
// Two-wire slave transmitter that returns quad converter channel contents.
// What this block does
// - Readback opens with address 10011, two pin bits, R/W low; match is acknowledged.
// - Control byte follows and is acknowledged; select bits 2:1, flag bit 0.
// - Repeated start, same address with R/W high, acknowledged, then device transmits.
// - Returned channel is the one selected by the latest control byte.
// - Flag clear: send exactly high byte then low byte.
// - Flag set: send power-down byte, high byte, low byte.
// - Power-down byte holds the mode bits on top, ones below.
// - High byte holds data 9..2; low byte holds data 1..0 on top.
// - Mode 00 and 11 high impedance, 01 one kilohm, 10 hundred kilohm.
// - Each channel holds twelve bits: two mode bits over ten data bits.
`timescale 1ns/1ns
module dri_readback
  import dri_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        addrPinHi,
  input  wire logic        addrPinLo,
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  output logic      [3:0]  pdHighZ,
  output logic      [3:0]  pd1k,
  output logic      [3:0]  pd100k
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus event detection.

  logic [1:0]        sclSync_reg;
  logic [1:0]        sdaSync_reg;
  logic [1:0]        pinHiSync_reg;
  logic [1:0]        pinLoSync_reg;
  logic              sclPrev_reg;
  logic              sdaPrev_reg;
  logic              sclRise;
  logic              sclFall;
  logic              startCond;
  logic              stopCond;
  logic [6:0]        ownAddr;

  // Every pin passes two flip-flops before anything reads it.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclSync_reg   <= 2'h3;
      sdaSync_reg   <= 2'h3;
      pinHiSync_reg <= 2'h0;
      pinLoSync_reg <= 2'h0;
    end else begin
      sclSync_reg   <= {sclSync_reg[0], scl};
      sdaSync_reg   <= {sdaSync_reg[0], sdaIn};
      pinHiSync_reg <= {pinHiSync_reg[0], addrPinHi};
      pinLoSync_reg <= {pinLoSync_reg[0], addrPinLo};
    end
  end

  // Previous synchronised levels for edge finding.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclSync_reg[1];
      sdaPrev_reg <= sdaSync_reg[1];
    end
  end

  // Start and stop are data edges while the clock line is high.
  assign sclRise   = sclSync_reg[1] && !sclPrev_reg;
  assign sclFall   = !sclSync_reg[1] && sclPrev_reg;
  assign startCond = sclSync_reg[1] && sclPrev_reg && !sdaSync_reg[1] && sdaPrev_reg;
  assign stopCond  = sclSync_reg[1] && sclPrev_reg && sdaSync_reg[1] && !sdaPrev_reg;
  assign ownAddr   = {ADDR_PREFIX, pinHiSync_reg[1], pinLoSync_reg[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers, control byte and register port.

  logic [CHAN_W-1:0] chan_reg [NUM_CHAN];
  logic [7:0]        ctrl_reg;
  logic [7:0]        rxShift_reg;
  logic              ctrlLoad;
  dri_state_e        state_reg;

  // Software loads the twelve-bit channel words over the register port.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_reg[i] <= CHAN_RESET;
      end
    end else if (regWrite && !regAddr[2]) begin
      chan_reg[regAddr[1:0]] <= regWrData[CHAN_W-1:0];
    end
  end

  // The most recent control byte steers which channel is read back.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrlLoad) begin
      ctrl_reg <= rxShift_reg;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      if (!regAddr[2]) begin
        regRdData <= {4'h0, chan_reg[regAddr[1:0]]};
      end else if (regAddr == REG_CTRL) begin
        regRdData <= {8'h00, ctrl_reg};
      end else if (regAddr == REG_STATUS) begin
        regRdData <= {13'h0000, sdaOe, state_reg != ST_IDLE, state_reg == ST_TX};
      end else begin
        regRdData <= 16'h0000;
      end
    end else begin
      regRdData <= 16'h0000;
    end
  end

  logic [NUM_CHAN-1:0] pdHighZ_next;
  logic [NUM_CHAN-1:0] pd1k_next;
  logic [NUM_CHAN-1:0] pd100k_next;

  // Power-down mode decode per channel, one loop over the channels.
  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_pd
      assign pd1k_next[c]    = chan_reg[c][PD_MODE_POS +: 2] == PD_MODE_1K;
      assign pd100k_next[c]  = chan_reg[c][PD_MODE_POS +: 2] == PD_MODE_100K;
      assign pdHighZ_next[c] = chan_reg[c][PD_MODE_POS +: 2] != PD_MODE_1K &&
                               chan_reg[c][PD_MODE_POS +: 2] != PD_MODE_100K;
    end
  endgenerate

  // One process registers all decode outputs, so each has a single driver.
  always_ff @(posedge clk) begin
    if (rst) begin
      pdHighZ <= 4'hf;
      pd1k    <= 4'h0;
      pd100k  <= 4'h0;
    end else begin
      pdHighZ <= pdHighZ_next;
      pd1k    <= pd1k_next;
      pd100k  <= pd100k_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback byte loader feeding the transmit FIFO.

  dri_stream_if txq ();

  dri_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_txFifo (
    .clk (clk),
    .rst (rst),
    .st  (txq.fifo)
  );

  logic [1:0]        loadLeft_reg;
  logic [1:0]        loadStart;
  logic              loadGo;
  logic [CHAN_W-1:0] selWord;
  logic              addrEnd;
  logic              addrMatch;

  // Channel picked by the select bits of the latest control byte.
  assign selWord = chan_reg[ctrl_reg[CTRL_SEL_POS +: 2]];
  assign loadStart = ctrl_reg[CTRL_PD_POS] ? BYTES_WITH_PD : BYTES_NO_PD;

  // Byte order: power-down byte, then high, then low.
  always_comb begin
    case (loadLeft_reg)
      2'h3:    txq.inData = {selWord[PD_MODE_POS +: 2], PD_BYTE_FILL};
      2'h2:    txq.inData = selWord[9:2];
      2'h1:    txq.inData = {selWord[1:0], LO_BYTE_FILL};
      default: txq.inData = IDLE_TX_BYTE;
    endcase
  end
  assign txq.inValid = loadLeft_reg != 2'h0;
  assign txq.flush   = startCond || stopCond;

  // The loader stalls while the FIFO refuses a byte.
  always_ff @(posedge clk) begin
    if (rst || startCond || stopCond) begin
      loadLeft_reg <= 2'h0;
    end else if (loadGo) begin
      loadLeft_reg <= loadStart;
    end else if (txq.inValid && txq.inReady) begin
      loadLeft_reg <= loadLeft_reg - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus protocol engine.

  logic [3:0] bitCnt_reg;
  logic [7:0] txShift_reg;
  logic       rw_reg;
  logic       mAck_reg;

  assign addrEnd   = state_reg == ST_ADDR && sclFall && bitCnt_reg == BITS_PER_BYTE;
  assign addrMatch = rxShift_reg[7:1] == ownAddr;
  assign loadGo    = addrEnd && addrMatch && rxShift_reg[0];
  assign ctrlLoad  = state_reg == ST_CTRL && sclFall && bitCnt_reg == BITS_PER_BYTE;
  assign txq.outReady = sclFall && ((state_reg == ST_ADDR_ACK && rw_reg) ||
                                    (state_reg == ST_MACK && mAck_reg));

  // Bits are sampled on clock rise; the state moves on clock fall.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (startCond) begin
      state_reg <= ST_ADDR;
    end else if (stopCond) begin
      state_reg <= ST_IDLE;
    end else if (sclFall) begin
      case (state_reg)
        ST_ADDR: begin
          if (bitCnt_reg == BITS_PER_BYTE) begin
            state_reg <= addrMatch ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: state_reg <= rw_reg ? ST_TX : ST_CTRL;
        ST_CTRL: begin
          if (bitCnt_reg == BITS_PER_BYTE) begin
            state_reg <= ST_CTRL_ACK;
          end
        end
        ST_CTRL_ACK: state_reg <= ST_IGNORE;
        ST_TX: begin
          if (bitCnt_reg == BITS_PER_BYTE) begin
            state_reg <= ST_MACK;
          end
        end
        ST_MACK: state_reg <= mAck_reg ? ST_TX : ST_IGNORE;
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Bit counter: counts rises, cleared when a byte phase opens.
  always_ff @(posedge clk) begin
    if (rst || startCond) begin
      bitCnt_reg <= 4'h0;
    end else if (sclFall && (state_reg == ST_ADDR_ACK || state_reg == ST_MACK)) begin
      bitCnt_reg <= 4'h0;
    end else if (sclRise && (state_reg == ST_ADDR || state_reg == ST_CTRL ||
                             state_reg == ST_TX)) begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  // Receive shifter for the address and control bytes.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxShift_reg <= 8'h00;
    end else if (sclRise && (state_reg == ST_ADDR || state_reg == ST_CTRL)) begin
      rxShift_reg <= {rxShift_reg[6:0], sdaSync_reg[1]};
    end
  end

  // Direction of the transfer, kept from the address byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      rw_reg <= 1'b0;
    end else if (addrEnd) begin
      rw_reg <= rxShift_reg[0];
    end
  end

  // Master acknowledge sampled on the ninth rise of a sent byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      mAck_reg <= 1'b0;
    end else if (sclRise && state_reg == ST_MACK) begin
      mAck_reg <= !sdaSync_reg[1];
    end
  end

  // Transmit shifter: loads from the FIFO, or all ones when it is empty.
  always_ff @(posedge clk) begin
    if (rst) begin
      txShift_reg <= IDLE_TX_BYTE;
    end else if (txq.outReady) begin
      txShift_reg <= txq.outValid ? txq.outData : IDLE_TX_BYTE;
    end else if (sclFall && state_reg == ST_TX && bitCnt_reg != BITS_PER_BYTE) begin
      txShift_reg <= {txShift_reg[6:0], 1'b1};
    end
  end

  // The line is only ever pulled low: for an ack or a zero data bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= (state_reg == ST_ADDR_ACK || state_reg == ST_CTRL_ACK) ||
               (state_reg == ST_TX && !txShift_reg[7]);
    end
  end
  assign sdaOut = 1'b0;

endmodule : dri_readback

// [verification/dri_asserts.sv]
// Concurrent checks on the readback block's top-level ports.
`timescale 1ns/1ns
module dri_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        scl,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic [2:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  input wire logic [3:0]  pdHighZ,
  input wire logic [3:0]  pd1k,
  input wire logic [3:0]  pd100k
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // A mode written into one channel through the register port.
  sequence s_mode_wr(logic [2:0] ch, logic [1:0] md);
    regWrite && regAddr == ch && regWrData[11:10] == md;
  endsequence
  // The bus clock seen high on two samples in a row.
  sequence s_scl_high;
    scl ##1 scl;
  endsequence
  a_open_drain_low: assert property (sdaOut == 1'h0)
    else $error("data pin output not low");
  a_oe_rise_sclow: assert property ($rose(sdaOe) |-> !scl)
    else $error("data line taken while clock high");
  a_oe_fall_sclow: assert property ($fell(sdaOe) |-> !scl)
    else $error("data line released while clock high");
  a_oe_holds_high: assert property (s_scl_high |-> $stable(sdaOe))
    else $error("driven bit changed in clock high phase");
  a_pd_decode_one: assert property ((pdHighZ | pd1k | pd100k) == 4'hf
    && (pdHighZ & pd1k) == 4'h0 && (pd1k & pd100k) == 4'h0
    && (pdHighZ & pd100k) == 4'h0)
    else $error("power-down decode not one per channel");
  a_pd_one_k: assert property (s_mode_wr(3'h1, 2'h1) |-> ##[1:3] pd1k[1])
    else $error("mode 01 not decoded");
  a_pd_hundred_k: assert property (s_mode_wr(3'h2, 2'h2) |-> ##[1:3] pd100k[2])
    else $error("mode 10 not decoded");
  a_pd_high_z: assert property (s_mode_wr(3'h3, 2'h3) |-> ##[1:3] pdHighZ[3])
    else $error("mode 11 not decoded");
  a_chan_twelve_bit: assert property (regRead && regAddr < 3'h4
    |=> regRdData[15:12] == 4'h0)
    else $error("channel wider than twelve bits");
endmodule : dri_asserts
bind dri_readback dri_asserts dri_asserts_i (
  .clk(clk), .rst(rst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .pdHighZ(pdHighZ),
  .pd1k(pd1k), .pd100k(pd100k));

// [verification/dri_master.sv]
// Behavioural two-wire bus master that reads channels back.
`timescale 1ns/1ns
module dri_master (
  output logic     scl,
  output logic     sdaLow,
  input wire logic sda
);
  // Clock stands high and data is released between frames.
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  // One 160 ns bit slot; returns the level sampled mid high phase.
  task automatic bitSlot(input logic b, output logic r);
    #20 sdaLow = ~b;
    #60 scl = 1'h1;
    #40 r = sda;
    #40 scl = 1'h0;
  endtask : bitSlot
  // Start, or repeated start when the clock is already low.
  task automatic start();
    #20 sdaLow = 1'h0;
    #60 scl = 1'h1;
    #40 sdaLow = 1'h1;
    #40 scl = 1'h0;
  endtask : start
  // Stop: data rises while the clock is high.
  task automatic stop();
    #20 sdaLow = 1'h1;
    #60 scl = 1'h1;
    #40 sdaLow = 1'h0;
  endtask : stop
  // Byte out MSB first, then the slave's acknowledge slot.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitSlot(d[i], r);
    bitSlot(1'h1, r);
    ack = ~r;
  endtask : wbyte
  // Byte in MSB first; acknowledge it only when ackIt is set.
  task automatic rbyte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(1'h1, r);
      d[i] = r;
    end
    bitSlot(~ackIt, r);
  endtask : rbyte
endmodule : dri_master

// [verification/testbench.sv]
// Self-checking bench for the readback block.
`timescale 1ns/1ns
module testbench;
  import dri_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        regWrite = 1'h0;
  logic        regRead = 1'h0;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWrData = 16'h0000;
  logic [1:0]  pins = 2'h0;
  logic [15:0] regRdData;
  logic [15:0] rd;
  logic [3:0]  pdHighZ;
  logic [3:0]  pd1k;
  logic [3:0]  pd100k;
  logic        scl;
  logic        sdaLow;
  logic        sdaOe;
  logic        sda;
  int          n_fail = 0;
  int          n_compared = 0;
  int          chan [4];
  always #5 clk = ~clk;
  // Open-drain data wire with a pull-up.
  assign sda = ~(sdaLow | sdaOe);
  dri_readback dri_readback_i (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sda),
    .sdaOut(), .sdaOe(sdaOe), .addrPinHi(pins[1]), .addrPinLo(pins[0]),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .pdHighZ(pdHighZ),
    .pd1k(pd1k), .pd100k(pd100k));
  dri_master dri_master_i (.scl(scl), .sdaLow(sdaLow), .sda(sda));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic regWr(logic [2:0] a, logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask : regWr
  task automatic regRd(logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'h0;
    #1 d = regRdData;
  endtask : regRd
  // Full readback; ap is the read address pin pair, which may mismatch.
  task automatic readback(logic [1:0] ap, logic [1:0] c, logic pd);
    logic [11:0] v;
    logic [7:0]  ctl;
    logic [7:0]  b;
    logic        ack;
    logic [7:0]  expQ [$];
    v = 12'(chan[c]);
    ctl = {2'h0, 2'($urandom), 1'h0, c, pd};
    // Model of the byte stream the device should return for this channel.
    if (pd) expQ.push_back({v[11:10], 6'h3f});
    expQ.push_back(v[9:2]);
    expQ.push_back({v[1:0], 6'h00});
    expQ.push_back(8'hff);
    dri_master_i.start();
    dri_master_i.wbyte({ADDR_PREFIX, pins, 1'h0}, ack);
    chk("ackAddrW", 16'h0001, 16'(ack));
    dri_master_i.wbyte(ctl, ack);
    chk("ackCtrl", 16'h0001, 16'(ack));
    dri_master_i.start();
    dri_master_i.wbyte({ADDR_PREFIX, ap, 1'h1}, ack);
    chk("ackAddrR", 16'(ap == pins), 16'(ack));
    for (int i = 0; i < 3; i++) begin
      dri_master_i.rbyte(i < 2, b);
      chk("rdByte", 16'((ap == pins) ? expQ.pop_front() : 8'hff), 16'(b));
    end
    regRd(REG_CTRL, rd);
    chk("ctrlReg", {8'h00, ctl}, rd);
    regRd(REG_STATUS, rd);
    chk("statusBusy", 16'h0002, rd);
  endtask : readback
  // Main sequence.
  initial begin
    void'($urandom(15));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    pins <= 2'($urandom);
    repeat (4) @(posedge clk);
    // Channel c carries power-down mode c, so every mode is seen.
    for (int c = 0; c < 4; c++) begin
      chan[c] = (c << 10) | ($urandom & 1023);
      regWr(3'(c), 16'(chan[c]));
    end
    for (int c = 0; c < 4; c++) begin
      regRd(3'(c), rd);
      chk("chanReg", 16'(chan[c]), rd);
    end
    regRd(3'h6, rd);
    chk("unmapped", 16'h0000, rd);
    chk("pdHighZ", 16'h0009, {12'h000, pdHighZ});
    chk("pd1k", 16'h0002, {12'h000, pd1k});
    chk("pd100k", 16'h0004, {12'h000, pd100k});
    #3;
    for (int pd = 0; pd < 2; pd++) begin
      for (int c = 0; c < 4; c++) readback(pins, 2'(c), pd[0]);
    end
    readback(pins ^ 2'($urandom_range(3, 1)), 2'h1, 1'h1);
    readback(pins, 2'h2, 1'h0);
    dri_master_i.stop();
    repeat (6) @(posedge clk);
    regRd(REG_STATUS, rd);
    chk("statusIdle", 16'h0000, rd);
    print_verdict();
  end
  // Watchdog at three times the expected run of about 10000 cycles.
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule : testbench
